// *** change_notify_detect.sv ***
// Change-of-state detection with sticky per-pin flags
`default_nettype none
module change_notify_detect
#(
	parameter int W = 32
)
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic [W-1:0] i_level,
	input wire logic [W-1:0] i_enable,
	input wire logic [W-1:0] i_clear,
	output logic [W-1:0] o_status,
	output logic o_irq
);
	logic [W-1:0] prev_q;
	logic primed_q;
	wire [W-1:0] event_w;

	assign event_w = primed_q ? (i_enable & (i_level ^ prev_q)) : '0;
	assign o_irq = |o_status;

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			prev_q <= '0;
			primed_q <= 1'b0;
			o_status <= '0;
		end
		else
		begin
			prev_q <= i_level;
			primed_q <= 1'b1;
			o_status <= (o_status & ~i_clear) | event_w;
		end
	end

	a_sticky_hold:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		1'b1 |=> ((o_status & $past(o_status & ~i_clear)) == $past(o_status & ~i_clear)))
	else $error("change flag dropped without clear");

	a_change_raises_irq:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(event_w != '0) |=> o_irq)
	else $error("enabled change did not raise request");
endmodule : change_notify_detect
`default_nettype wire

// *** gpio_port_pkg.sv ***
// Constants, register map and types shared by the I/O port block
`default_nettype none
package gpio_port_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int PIN_W = 32;
	localparam int FIELD_W = 6;
	localparam int ADDR_W = 8;
	localparam int FUNC_W = 64;
	// ----------------------------------------------------------------
	// Register word offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_DIR_LO = 8'h00;
	localparam logic [7:0] OFS_DIR_HI = 8'h01;
	localparam logic [7:0] OFS_LAT_LO = 8'h02;
	localparam logic [7:0] OFS_LAT_HI = 8'h03;
	localparam logic [7:0] OFS_LVL_LO = 8'h04;
	localparam logic [7:0] OFS_LVL_HI = 8'h05;
	localparam logic [7:0] OFS_ODC_LO = 8'h06;
	localparam logic [7:0] OFS_ODC_HI = 8'h07;
	localparam logic [7:0] OFS_ANA = 8'h08;
	localparam logic [7:0] OFS_CEN_LO = 8'h09;
	localparam logic [7:0] OFS_CEN_HI = 8'h0a;
	localparam logic [7:0] OFS_PU_LO = 8'h0b;
	localparam logic [7:0] OFS_PU_HI = 8'h0c;
	localparam logic [7:0] OFS_CST_LO = 8'h0d;
	localparam logic [7:0] OFS_CST_HI = 8'h0e;
	localparam logic [7:0] OFS_OSC = 8'h0f;
	localparam logic [7:0] OFS_IMAP_BASE = 8'h20;
	localparam logic [7:0] OFS_OMAP_BASE = 8'h40;
	// ----------------------------------------------------------------
	// Reset values and keys
	// ----------------------------------------------------------------
	localparam logic [31:0] DIR_RST = 32'hffff_ffff;
	localparam logic [15:0] ANA_RST = 16'h0000;
	localparam logic [5:0] OMAP_DEFAULT = 6'h00;
	localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
	localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
	localparam int LOCK_BIT_POS = 6;
	localparam logic LOCK_RST = 1'b0;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_KEY1 = 2'b01,
		LK_OPEN = 2'b11
	} unlock_state_t;
endpackage : gpio_port_pkg
`default_nettype wire

// *** gpio_port_top.sv ***
// Shared I/O port with change notification and pin remap entry
//
// Implementation choices: the address-and-strobe port and the address map.
`default_nettype none
// Functional notes
// - Driving peripheral disables port driver, read stays
// - Enabled but idle peripheral lets port drive
// - Port output never loops into peripheral input
// - Direction one is input, zero output
// - Reset makes every pin an input
// - Latch register reads and writes the latch
// - Port read gives pins, write hits latch
// - Unimplemented bits read zero, writes ignored
// - Open-drain bit removes active high drive; here only for port drive, a driving peripheral still drives high
// - Analog config resets to zero, all analog
// - Analog pins read zero from port register
// - Enabled pin change raises interrupt request
// - Per-pin change enables in two registers
// - Per-pin pull-up enables in two registers
// - Peripheral inputs and outputs map independently
// - Up to thirty remappable pins, variant dependent
// - Six-bit input field picks source pin
// - Output field zero keeps default port function
// - Map writes only when lock clear, keyed
module gpio_port_top
#(
	parameter logic [31:0] IMPL_MASK = 32'h3fff_ffff,
	parameter logic [15:0] ANALOG_MASK = 16'h00ff,
	parameter int N_IN_MAP = 4
)
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic [31:0] i_pin_in,
	output logic [31:0] o_pin_out,
	output logic [31:0] o_pin_oe,
	output logic [31:0] o_pullup_en,
	output logic [15:0] o_analog_sel,
	input wire logic [31:0] i_periph_en,
	input wire logic [31:0] i_periph_drive,
	input wire logic [31:0] i_periph_out,
	output logic [31:0] o_periph_in,
	input wire logic [63:0] i_func_out,
	input wire logic [63:0] i_func_drive,
	output logic [N_IN_MAP-1:0] o_func_in,
	output logic o_change_irq,
	output logic o_map_locked
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0] dir_q;
	logic [31:0] lat_q;
	logic [31:0] odc_q;
	logic [31:0] cen_q;
	logic [31:0] pu_q;
	logic [15:0] ana_q;
	logic lock_q;
	logic lock_d;
	gpio_port_pkg::unlock_state_t lk_q;
	gpio_port_pkg::unlock_state_t lk_d;
	logic [5:0] imap_q [N_IN_MAP];
	logic [5:0] omap_q [32];
	logic [31:0] level_w;
	logic [31:0] periph_act_w;
	logic [31:0] cst_w;
	logic [31:0] analog_mode_w;

	function automatic logic [31:0] merge16(input logic [31:0] old, input logic we_lo,
		input logic we_hi, input logic [15:0] d);
		logic [31:0] r;
		r = old;
		if (we_lo)
			r[15:0] = d;
		if (we_hi)
			r[31:16] = d;
		return r & IMPL_MASK;
	endfunction : merge16

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire wr_dir_lo = i_wr & (i_addr == gpio_port_pkg::OFS_DIR_LO);
	wire wr_dir_hi = i_wr & (i_addr == gpio_port_pkg::OFS_DIR_HI);
	wire wr_lat_lo = i_wr & ((i_addr == gpio_port_pkg::OFS_LAT_LO) |
		(i_addr == gpio_port_pkg::OFS_LVL_LO));
	wire wr_lat_hi = i_wr & ((i_addr == gpio_port_pkg::OFS_LAT_HI) |
		(i_addr == gpio_port_pkg::OFS_LVL_HI));
	wire wr_odc_lo = i_wr & (i_addr == gpio_port_pkg::OFS_ODC_LO);
	wire wr_odc_hi = i_wr & (i_addr == gpio_port_pkg::OFS_ODC_HI);
	wire wr_cen_lo = i_wr & (i_addr == gpio_port_pkg::OFS_CEN_LO);
	wire wr_cen_hi = i_wr & (i_addr == gpio_port_pkg::OFS_CEN_HI);
	wire wr_pu_lo = i_wr & (i_addr == gpio_port_pkg::OFS_PU_LO);
	wire wr_pu_hi = i_wr & (i_addr == gpio_port_pkg::OFS_PU_HI);
	wire wr_cst_lo = i_wr & (i_addr == gpio_port_pkg::OFS_CST_LO);
	wire wr_cst_hi = i_wr & (i_addr == gpio_port_pkg::OFS_CST_HI);
	wire wr_ana = i_wr & (i_addr == gpio_port_pkg::OFS_ANA);
	wire wr_osc = i_wr & (i_addr == gpio_port_pkg::OFS_OSC);
	wire [7:0] imap_idx = i_addr - gpio_port_pkg::OFS_IMAP_BASE;
	wire [7:0] omap_idx = i_addr - gpio_port_pkg::OFS_OMAP_BASE;
	wire in_imap = (i_addr >= gpio_port_pkg::OFS_IMAP_BASE) &
		(imap_idx < 8'(N_IN_MAP));
	wire in_omap = (i_addr >= gpio_port_pkg::OFS_OMAP_BASE) & (omap_idx < 8'd32);
	wire map_we = i_wr & ~lock_q;
	wire [31:0] cst_clr = {wr_cst_hi ? i_wdata : 16'h0000, wr_cst_lo ? i_wdata : 16'h0000};

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			dir_q <= gpio_port_pkg::DIR_RST & IMPL_MASK;
			lat_q <= '0;
			odc_q <= '0;
			cen_q <= '0;
			pu_q <= '0;
			ana_q <= gpio_port_pkg::ANA_RST;
		end
		else
		begin
			dir_q <= merge16(dir_q, wr_dir_lo, wr_dir_hi, i_wdata);
			lat_q <= merge16(lat_q, wr_lat_lo, wr_lat_hi, i_wdata);
			odc_q <= merge16(odc_q, wr_odc_lo, wr_odc_hi, i_wdata);
			cen_q <= merge16(cen_q, wr_cen_lo, wr_cen_hi, i_wdata);
			pu_q <= merge16(pu_q, wr_pu_lo, wr_pu_hi, i_wdata);
			if (wr_ana)
				ana_q <= i_wdata & ANALOG_MASK;
		end
	end

	assign o_pullup_en = pu_q;
	assign analog_mode_w = {16'h0000, ANALOG_MASK & ~ana_q};
	assign o_analog_sel = ANALOG_MASK & ~ana_q;

	// ----------------------------------------------------------------
	// Map lock sequence
	// ----------------------------------------------------------------
	always_comb
	begin
		lk_d = lk_q;
		lock_d = lock_q;
		case (lk_q)
			gpio_port_pkg::LK_IDLE:
				if (wr_osc && i_wdata[7:0] == gpio_port_pkg::UNLOCK_KEY1)
					lk_d = gpio_port_pkg::LK_KEY1;
			gpio_port_pkg::LK_KEY1:
				if (wr_osc)
					lk_d = (i_wdata[7:0] == gpio_port_pkg::UNLOCK_KEY2) ?
						gpio_port_pkg::LK_OPEN : gpio_port_pkg::LK_IDLE;
			gpio_port_pkg::LK_OPEN:
				if (wr_osc)
				begin
					lock_d = i_wdata[gpio_port_pkg::LOCK_BIT_POS];
					lk_d = gpio_port_pkg::LK_IDLE;
				end
			default:
				lk_d = gpio_port_pkg::LK_IDLE;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			lk_q <= gpio_port_pkg::LK_IDLE;
			lock_q <= gpio_port_pkg::LOCK_RST;
		end
		else
		begin
			lk_q <= lk_d;
			lock_q <= lock_d;
		end
	end

	assign o_map_locked = lock_q;

	// ----------------------------------------------------------------
	// Mapping registers and pins
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_IN_MAP; g++)
		begin : g_imap
			always_ff @(posedge i_clock)
			begin
				if (i_sys_rst)
					imap_q[g] <= gpio_port_pkg::OMAP_DEFAULT;
				else if (map_we && in_imap && imap_idx == 8'(g))
					imap_q[g] <= i_wdata[5:0];
			end
			assign o_func_in[g] = imap_q[g][5] ? 1'b0 : o_periph_in[imap_q[g][4:0]];
		end
		for (g = 0; g < 32; g++)
		begin : g_pin
			always_ff @(posedge i_clock)
			begin
				if (i_sys_rst)
					omap_q[g] <= gpio_port_pkg::OMAP_DEFAULT;
				else if (map_we && in_omap && omap_idx == 8'(g) && IMPL_MASK[g])
					omap_q[g] <= i_wdata[5:0];
			end
			assign periph_act_w[g] = (omap_q[g] != gpio_port_pkg::OMAP_DEFAULT) ?
				i_func_drive[omap_q[g]] : (i_periph_en[g] & i_periph_drive[g]);
			io_pin_cell u_cell
			(
				.i_clock(i_clock),
				.i_sys_rst(i_sys_rst),
				.i_pin_raw(i_pin_in[g]),
				.i_impl(IMPL_MASK[g]),
				.i_dir(dir_q[g]),
				.i_lat(lat_q[g]),
				.i_odc(odc_q[g]),
				.i_analog(analog_mode_w[g]),
				.i_periph_act(periph_act_w[g]),
				.i_periph_out((omap_q[g] != gpio_port_pkg::OMAP_DEFAULT) ?
					i_func_out[omap_q[g]] : i_periph_out[g]),
				.o_pin_out(o_pin_out[g]),
				.o_pin_oe(o_pin_oe[g]),
				.o_level(level_w[g]),
				.o_periph_in(o_periph_in[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Change notification
	// ----------------------------------------------------------------
	change_notify_detect #(.W(32)) u_change
	(
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_level(level_w),
		.i_enable(cen_q & IMPL_MASK),
		.i_clear(cst_clr),
		.o_status(cst_w),
		.o_irq(o_change_irq)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire [15:0] rd_mux =
		(i_addr == gpio_port_pkg::OFS_DIR_LO) ? dir_q[15:0] :
		(i_addr == gpio_port_pkg::OFS_DIR_HI) ? dir_q[31:16] :
		(i_addr == gpio_port_pkg::OFS_LAT_LO) ? lat_q[15:0] :
		(i_addr == gpio_port_pkg::OFS_LAT_HI) ? lat_q[31:16] :
		(i_addr == gpio_port_pkg::OFS_LVL_LO) ? level_w[15:0] :
		(i_addr == gpio_port_pkg::OFS_LVL_HI) ? level_w[31:16] :
		(i_addr == gpio_port_pkg::OFS_ODC_LO) ? odc_q[15:0] :
		(i_addr == gpio_port_pkg::OFS_ODC_HI) ? odc_q[31:16] :
		(i_addr == gpio_port_pkg::OFS_ANA) ? ana_q :
		(i_addr == gpio_port_pkg::OFS_CEN_LO) ? cen_q[15:0] :
		(i_addr == gpio_port_pkg::OFS_CEN_HI) ? cen_q[31:16] :
		(i_addr == gpio_port_pkg::OFS_PU_LO) ? pu_q[15:0] :
		(i_addr == gpio_port_pkg::OFS_PU_HI) ? pu_q[31:16] :
		(i_addr == gpio_port_pkg::OFS_CST_LO) ? cst_w[15:0] :
		(i_addr == gpio_port_pkg::OFS_CST_HI) ? cst_w[31:16] :
		(i_addr == gpio_port_pkg::OFS_OSC) ? 16'(lock_q) << gpio_port_pkg::LOCK_BIT_POS :
		in_imap ? {10'h000, imap_q[imap_idx[1:0] & 2'(N_IN_MAP - 1)]} :
		in_omap ? {10'h000, omap_q[omap_idx[4:0]]} :
		16'h0000;

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			o_rdata <= 16'h0000;
		else
			o_rdata <= i_rd ? rd_mux : 16'h0000;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_dir_after_reset:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		$past(i_sys_rst) |-> (dir_q == IMPL_MASK) && (ana_q == 16'h0000))
	else $error("pins not inputs after reset");

	a_analog_reset:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		$past(i_sys_rst) |-> (o_analog_sel == ANALOG_MASK))
	else $error("analog config not all analog after reset");

	a_latch_write:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(i_wr && i_addr == gpio_port_pkg::OFS_LAT_LO) |=>
		lat_q[15:0] == ($past(i_wdata) & IMPL_MASK[15:0]))
	else $error("latch write lost");

	a_port_write_latch:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(i_wr && i_addr == gpio_port_pkg::OFS_LVL_HI) |=>
		lat_q[31:16] == ($past(i_wdata) & IMPL_MASK[31:16]))
	else $error("port write did not reach latch");

	a_analog_reads_zero:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(i_rd && i_addr == gpio_port_pkg::OFS_LVL_LO) |=>
		(o_rdata & $past(analog_mode_w[15:0])) == 16'h0000)
	else $error("analog pin read nonzero");

	a_unimpl_zero:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		((dir_q | lat_q | level_w) & ~IMPL_MASK) == 32'h0000_0000)
	else $error("unimplemented bit nonzero");

	a_map_lock_holds:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(lock_q && i_wr && i_addr == (gpio_port_pkg::OFS_OMAP_BASE + 8'h03)) |=>
		omap_q[3] == $past(omap_q[3]))
	else $error("map changed while locked");

	a_periph_owns_pin:
	assert property (@(posedge i_clock) disable iff (i_sys_rst)
		(omap_q[0] == gpio_port_pkg::OMAP_DEFAULT && i_periph_en[0] && i_periph_drive[0]
		&& IMPL_MASK[0]) |-> o_pin_oe[0] && (o_pin_out[0] == i_periph_out[0]))
	else $error("port drove pin owned by peripheral");
endmodule : gpio_port_top
`default_nettype wire

// *** io_pin_cell.sv ***
// One pin: input synchroniser and output ownership multiplexers
`default_nettype none
module io_pin_cell
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_pin_raw,
	input wire logic i_impl,
	input wire logic i_dir,
	input wire logic i_lat,
	input wire logic i_odc,
	input wire logic i_analog,
	input wire logic i_periph_act,
	input wire logic i_periph_out,
	output logic o_pin_out,
	output logic o_pin_oe,
	output logic o_level,
	output logic o_periph_in
);
	logic sync1_q;
	logic sync2_q;
	wire port_drv;

	// ----------------------------------------------------------------
	// Input synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else
		begin
			sync1_q <= i_pin_raw;
			sync2_q <= sync1_q;
		end
	end

	// ----------------------------------------------------------------
	// Ownership
	// ----------------------------------------------------------------
	assign port_drv = i_impl & ~i_periph_act & ~i_dir;
	assign o_pin_oe = i_periph_act | (port_drv & ~(i_odc & i_lat));
	assign o_pin_out = i_periph_act ? i_periph_out : (i_lat & ~i_odc);
	assign o_level = sync2_q & ~i_analog & i_impl;
	assign o_periph_in = sync2_q & ~port_drv & i_impl;
endmodule : io_pin_cell
`default_nettype wire

// *** pin_partner.sv ***
// Behavioural model of the pads and the board around the port
`default_nettype none
module pin_partner
(
	input wire logic i_clock,
	input wire logic [31:0] i_pin_out,
	input wire logic [31:0] i_pin_oe,
	input wire logic [31:0] i_pullup_en,
	input wire logic [31:0] i_ext_val,
	input wire logic [31:0] i_ext_en,
	output logic [31:0] o_pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] float_q = 32'h0000_0000;
	// Undriven pins without pull-up wander every cycle
	always @(posedge i_clock) float_q <= ~float_q;
	// Port driver wins, then the board, then the pull-up
	assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext_val)
		| (~i_pin_oe & ~i_ext_en & (i_pullup_en | float_q));
endmodule : pin_partner
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench of the shared I/O port
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic [31:0] ext_val = 32'h0000_0000;
	logic [31:0] ext_en = 32'hffff_ffff;
	logic [31:0] periph_en = 32'h0000_0000;
	logic [31:0] periph_drive = 32'h0000_0000;
	logic [31:0] periph_out = 32'h0000_0000;
	logic [63:0] func_out = 64'h0000_0000_0000_0000;
	logic [63:0] func_drive = 64'h0000_0000_0000_0000;
	logic [15:0] o_rdata;
	logic [31:0] pin_level;
	logic [31:0] o_pin_out;
	logic [31:0] o_pin_oe;
	logic [31:0] o_pullup_en;
	logic [31:0] periph_in;
	logic [15:0] analog_sel;
	logic [3:0] func_in;
	logic change_irq;
	logic map_locked;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	// ----------------------------------------------------------------
	// Clock, design and pads
	// ----------------------------------------------------------------
	initial
	begin
		forever #2 i_clock = ~i_clock;
	end
	gpio_port_top uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pin_level),
		.o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en),
		.o_analog_sel(analog_sel), .i_periph_en(periph_en), .i_periph_drive(periph_drive),
		.i_periph_out(periph_out), .o_periph_in(periph_in), .i_func_out(func_out),
		.i_func_drive(func_drive), .o_func_in(func_in), .o_change_irq(change_irq),
		.o_map_locked(map_locked));
	pin_partner pads (.i_clock(i_clock), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
		.i_pullup_en(o_pullup_en), .i_ext_val(ext_val), .i_ext_en(ext_en),
		.o_pin_level(pin_level));
	// ----------------------------------------------------------------
	// Bus tasks and checks
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : cyc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk({16'h0000, o_rdata}, {16'h0000, exp});
	endtask : rchk
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	always @(posedge i_clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			errors++;
			give_verdict();
		end
	end
	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		rchk(gpio_port_pkg::OFS_DIR_LO, 16'hffff);
		rchk(gpio_port_pkg::OFS_DIR_HI, 16'h3fff);
		rchk(gpio_port_pkg::OFS_ANA, 16'h0000);
		rchk(8'h1f, 16'h0000);
		chk(o_pin_oe, 32'h0000_0000);
		chk({16'h0000, analog_sel}, 32'h0000_00ff);
		$display("test reset done");
		wr(gpio_port_pkg::OFS_LAT_HI, 16'hffff);
		rchk(gpio_port_pkg::OFS_LAT_HI, 16'h3fff);
		wr(gpio_port_pkg::OFS_DIR_HI, 16'h0000);
		chk(o_pin_oe, 32'h3fff_0000);
		chk(o_pin_out & o_pin_oe, 32'h3fff_0000);
		wr(gpio_port_pkg::OFS_DIR_HI, 16'hffff);
		wr(gpio_port_pkg::OFS_LAT_HI, 16'h0000);
		$display("test latch done");
		ext_val <= 32'hffff_a5c3;
		cyc(4);
		rchk(gpio_port_pkg::OFS_LVL_LO, 16'ha500);
		rchk(gpio_port_pkg::OFS_LVL_HI, 16'h3fff);
		wr(gpio_port_pkg::OFS_ANA, 16'hffff);
		cyc(2);
		rchk(gpio_port_pkg::OFS_LVL_LO, 16'ha5c3);
		ext_val <= 32'h0000_0000;
		$display("test level done");
		wr(gpio_port_pkg::OFS_LVL_LO, 16'h1234);
		rchk(gpio_port_pkg::OFS_LAT_LO, 16'h1234);
		wr(gpio_port_pkg::OFS_DIR_LO, 16'h0000);
		chk(o_pin_oe[15:0], 16'hffff);
		cyc(4);
		rchk(gpio_port_pkg::OFS_LVL_LO, 16'h1234);
		chk(periph_in[15:0], 16'h0000);
		periph_en <= 32'h0000_0001;
		cyc(1);
		chk({o_pin_oe[0], o_pin_out[0]}, 2'b10);
		periph_drive <= 32'h0000_0001;
		periph_out <= 32'h0000_0001;
		cyc(4);
		chk({o_pin_oe[0], o_pin_out[0]}, 2'b11);
		rchk(gpio_port_pkg::OFS_LVL_LO, 16'h1235);
		periph_en <= 32'h0000_0000;
		periph_drive <= 32'h0000_0000;
		wr(gpio_port_pkg::OFS_LAT_LO, 16'h1236);
		wr(gpio_port_pkg::OFS_ODC_LO, 16'h0006);
		chk(o_pin_oe[3:0], 4'b1001);
		wr(gpio_port_pkg::OFS_ODC_LO, 16'h0000);
		wr(gpio_port_pkg::OFS_DIR_LO, 16'hffff);
		$display("test direction done");
		wr(gpio_port_pkg::OFS_CEN_HI, 16'h0010);
		cyc(4);
		rchk(gpio_port_pkg::OFS_CST_HI, 16'h0000);
		ext_val[21] <= 1'b1;
		cyc(6);
		chk(change_irq, 1'b0);
		ext_val[20] <= 1'b1;
		for (int n = 0; n < 6 && change_irq !== 1'b1; n++)
			cyc(1);
		chk(change_irq, 1'b1);
		rchk(gpio_port_pkg::OFS_CST_HI, 16'h0010);
		wr(gpio_port_pkg::OFS_CST_HI, 16'h0010);
		rchk(gpio_port_pkg::OFS_CST_HI, 16'h0000);
		chk(change_irq, 1'b0);
		$display("test change done");
		wr(gpio_port_pkg::OFS_PU_LO, 16'h8001);
		wr(gpio_port_pkg::OFS_PU_HI, 16'hffff);
		chk(o_pullup_en, 32'h3fff_8001);
		ext_en[15] <= 1'b0;
		cyc(4);
		rchk(gpio_port_pkg::OFS_LVL_LO, 16'h8000);
		ext_en[15] <= 1'b1;
		$display("test pullup done");
		wr(gpio_port_pkg::OFS_IMAP_BASE, 16'h0005);
		ext_val[5] <= 1'b1;
		cyc(4);
		chk(func_in[0], 1'b1);
		ext_val[5] <= 1'b0;
		cyc(4);
		chk(func_in[0], 1'b0);
		func_drive[45] <= 1'b1;
		func_out[45] <= 1'b1;
		wr(gpio_port_pkg::OFS_OMAP_BASE + 8'h03, 16'h002d);
		chk({o_pin_oe[4:3], o_pin_out[3]}, 3'b011);
		wr(gpio_port_pkg::OFS_OSC, 16'h0046);
		wr(gpio_port_pkg::OFS_OSC, 16'h0057);
		wr(gpio_port_pkg::OFS_OSC, 16'h0040);
		chk(map_locked, 1'b1);
		wr(gpio_port_pkg::OFS_OMAP_BASE + 8'h03, 16'h0000);
		chk(o_pin_oe[3], 1'b1);
		wr(gpio_port_pkg::OFS_OSC, 16'h0046);
		wr(gpio_port_pkg::OFS_OSC, 16'h0057);
		wr(gpio_port_pkg::OFS_OSC, 16'h0000);
		chk(map_locked, 1'b0);
		wr(gpio_port_pkg::OFS_OSC, 16'h0046);
		wr(gpio_port_pkg::OFS_OSC, 16'h0012);
		wr(gpio_port_pkg::OFS_OSC, 16'h0040);
		chk(map_locked, 1'b0);
		wr(gpio_port_pkg::OFS_OMAP_BASE + 8'h03, 16'h0000);
		chk(o_pin_oe[3], 1'b0);
		$display("test remap done");
		give_verdict();
	end
endmodule : tb
`default_nettype wire
